// ### src/pwmst_top.sv
// Functional notes
// - steering mode only when mode upper bits are 11 and configuration is 00
// - either pin may carry the waveform, chosen by its steering enable
// - while steering, every enabled pin carries the identical waveform at the same time
// - low two mode bits set each pin polarity while steering
// - shutdown forces only pins enabled for PWM (the steered pins while steering); other pins untouched
// - sync bit 0: new steering applies right after the write
// - sync bit 1: new steering waits for the next period start
// - period flag sets as the second period begins
// - unimplemented bits read as zero
// - pins may move to alternate locations by relocation register
// - after reset all pins are high impedance until drivers enabled
// - shutdown drives each pin to one, zero or high impedance
// - shutdown event sets status, held until firmware clear or restart
// - auto-restart clears status in hardware at the next period start after condition goes away
// - half-bridge delays each rising transition by the dead-band count
//
// The Avalon-MM interface to the registers and the address map were decided locally.
module pwmst_top
    import pwmst_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic period_match,
    input wire logic duty_active,
    input wire logic [2:0] shutdown_inputs,
    input wire logic [1:0] port_data,
    output logic [1:0] pin_primary_out,
    output logic [1:0] pin_primary_oe,
    output logic [1:0] pin_alternate_out,
    output logic [1:0] pin_alternate_oe
);
    import pwmst_pkg::*;

    typedef enum logic [1:0] {PWMST_IDLE, PWMST_ARMED, PWMST_RUNNING} pwmst_state_t;

    logic [7:0] reloc_ff;
    logic [7:0] mode_ff;
    logic [7:0] shdn_ff;
    logic [7:0] steer_ff;
    logic [7:0] rstdb_ff;
    logic [7:0] dir_ff;
    logic [1:0] active_en_ff;
    logic flag_ff;
    logic ack_ff;
    logic [31:0] rdata_ff;
    logic [1:0] pin_q_ff;
    logic [1:0] pin_oe_ff;
    pwmst_state_t state_ff;
    pwmst_state_t nxt_state;
    logic [7:0] nxt_shdn;
    logic [1:0] nxt_active;
    logic nxt_flag;

    // byte-lane merge of a write into a register
    function automatic logic [7:0] pwmst_merge(input logic [7:0] old, input logic [7:0] mask);
        pwmst_merge = avs_byteenable[0] ? (avs_writedata[7:0] & mask) : old;
    endfunction

    // drive value for a pin in shutdown: data then enable
    function automatic logic [1:0] pwmst_sd_drive(input logic [1:0] ss);
        case (ss)
            PWMST_SS_LOW: pwmst_sd_drive = 2'h1;
            PWMST_SS_HIGH: pwmst_sd_drive = 2'h3;
            default: pwmst_sd_drive = 2'h0;
        endcase
    endfunction

    // bus decode: answer one cycle after the request is seen
    wire req = (avs_read | avs_write) & ~ack_ff;
    wire wr_go = avs_write & ack_ff;
    wire sel_reloc = avs_address == {1'b0, PWMST_OFS_RELOC};
    wire sel_mode = avs_address == {1'b0, PWMST_OFS_MODE};
    wire sel_shdn = avs_address == {1'b0, PWMST_OFS_SHDN};
    wire sel_steer = avs_address == {1'b0, PWMST_OFS_STEER};
    wire sel_rstdb = avs_address == PWMST_OFS_RSTDB;
    wire sel_flag = avs_address == PWMST_OFS_FLAG;
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;

    // mode decode
    wire [1:0] cfg = mode_ff[PWMST_MODE_CFG_LSB +: 2];
    wire pwm_on = mode_ff[PWMST_MODE_SEL_HI +: 2] == PWMST_SEL_PWM;
    wire steer_mode = pwm_on & (cfg == PWMST_CFG_SINGLE);
    wire half_mode = pwm_on & (cfg == PWMST_CFG_HALF);
    wire pol_a_low = mode_ff[1];
    wire pol_b_low = mode_ff[0];

    // shutdown: any selected source, level based
    wire sd_cond = |(shdn_ff[PWMST_SD_SRC_LSB +: 3] & shutdown_inputs);
    wire sd_status = shdn_ff[PWMST_SD_STATUS];
    wire shdn_wr = wr_go & sel_shdn;
    wire steer_wr = wr_go & sel_steer;
    wire sync_mode = steer_ff[PWMST_ST_SYNC];

    // status: set wins over clear, firmware write blocked while condition holds
    always_comb begin
        nxt_shdn = shdn_ff;
        if (shdn_wr) begin
            nxt_shdn = pwmst_merge(shdn_ff, 8'hFF);
        end
        if (sd_cond) begin
            nxt_shdn[PWMST_SD_STATUS] = 1'b1;
        end else if (rstdb_ff[PWMST_RS_EN] && period_match) begin
            nxt_shdn[PWMST_SD_STATUS] = 1'b0;
        end
    end

    // steering enables: immediate or at the period boundary via shadow
    always_comb begin
        nxt_active = active_en_ff;
        if (steer_wr && !avs_writedata[PWMST_ST_SYNC]) begin
            nxt_active = avs_writedata[1:0];
        end else if (sync_mode && period_match) begin
            nxt_active = steer_ff[1:0];
        end
    end

    // start-up: waveform waits for a period start, flag on second period
    always_comb begin
        nxt_state = state_ff;
        nxt_flag = flag_ff;
        case (state_ff)
            PWMST_IDLE: if (pwm_on && period_match) nxt_state = PWMST_ARMED;
            PWMST_ARMED: if (period_match) begin
                nxt_state = PWMST_RUNNING;
            end
            PWMST_RUNNING: if (!pwm_on) nxt_state = PWMST_IDLE;
            default: nxt_state = PWMST_IDLE;
        endcase
        if (!pwm_on) nxt_state = PWMST_IDLE;
        if (wr_go && sel_flag && avs_byteenable[0] && !avs_writedata[0]) nxt_flag = 1'b0;
        if (period_match && state_ff != PWMST_IDLE) nxt_flag = 1'b1;
    end

    // half-bridge dead band on each phase
    logic db_a;
    logic db_b;
    wire run = state_ff != PWMST_IDLE;
    pwmst_deadband u_db_a (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .delay_count(rstdb_ff[6:0]),
        .level_in(run & duty_active),
        .level_out(db_a)
    );
    pwmst_deadband u_db_b (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .delay_count(rstdb_ff[6:0]),
        .level_in(run & ~duty_active),
        .level_out(db_b)
    );

    // per-pin function select
    wire raw = run & duty_active;
    wire en_a = steer_mode ? active_en_ff[0] : (pwm_on & ~steer_mode);
    wire en_b = steer_mode ? active_en_ff[1] : half_mode;
    wire wave_a = half_mode ? db_a : raw;
    wire wave_b = half_mode ? db_b : raw;
    wire [1:0] sd_a = pwmst_sd_drive(shdn_ff[PWMST_SD_A_LSB +: 2]);
    wire [1:0] sd_b = pwmst_sd_drive(shdn_ff[PWMST_SD_B_LSB +: 2]);
    wire lvl_a = (en_a & sd_status) ? sd_a[1] : (en_a ? wave_a ^ pol_a_low : port_data[0]);
    wire lvl_b = (en_b & sd_status) ? sd_b[1] : (en_b ? wave_b ^ pol_b_low : port_data[1]);
    wire drv_a = ~dir_ff[0] & ((en_a & sd_status) ? sd_a[0] : 1'b1);
    wire drv_b = ~dir_ff[1] & ((en_b & sd_status) ? sd_b[0] : 1'b1);

    // read mux, unimplemented bits zero
    wire [7:0] rd_byte = sel_reloc ? reloc_ff :
                         sel_mode ? mode_ff :
                         sel_shdn ? shdn_ff :
                         sel_steer ? steer_ff :
                         sel_rstdb ? rstdb_ff :
                         sel_flag ? {dir_ff[1:0], 5'h00, flag_ff} : 8'h00;

    // register and bus state
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            reloc_ff <= PWMST_RST_BYTE;
            mode_ff <= PWMST_RST_BYTE;
            shdn_ff <= PWMST_RST_BYTE;
            steer_ff <= PWMST_RST_STEER;
            rstdb_ff <= PWMST_RST_BYTE;
            dir_ff <= PWMST_RST_DIR;
            active_en_ff <= PWMST_RST_STEER[1:0];
            flag_ff <= 1'b0;
            ack_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            state_ff <= PWMST_IDLE;
        end else begin
            ack_ff <= req;
            rdata_ff <= {24'h00_0000, rd_byte};
            if (wr_go && sel_reloc) reloc_ff <= pwmst_merge(reloc_ff, PWMST_RELOC_MASK);
            if (wr_go && sel_mode) mode_ff <= pwmst_merge(mode_ff, 8'hFF);
            if (steer_wr) steer_ff <= pwmst_merge(steer_ff, PWMST_ST_MASK);
            if (wr_go && sel_rstdb) rstdb_ff <= pwmst_merge(rstdb_ff, 8'hFF);
            if (wr_go && sel_flag && avs_byteenable[0]) dir_ff <= {6'h00, avs_writedata[7:6]};
            shdn_ff <= nxt_shdn;
            active_en_ff <= nxt_active;
            flag_ff <= nxt_flag;
            state_ff <= nxt_state;
        end
    end

    // registered pin stage
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pin_q_ff <= 2'h0;
            pin_oe_ff <= 2'h0;
        end else begin
            pin_q_ff <= {lvl_b, lvl_a};
            pin_oe_ff <= {drv_b, drv_a};
        end
    end

    // relocation: each pin sits at primary or alternate location
    assign pin_primary_out = pin_q_ff;
    assign pin_alternate_out = pin_q_ff;
    assign pin_primary_oe = pin_oe_ff & ~reloc_ff[1:0];
    assign pin_alternate_oe = pin_oe_ff & reloc_ff[1:0];
    assign avs_readdata = rdata_ff;
endmodule

// ### src/pwmst_pkg.sv
package pwmst_pkg;
    // register offsets (byte addresses, one word each)
    localparam logic [3:0] PWMST_OFS_RELOC = 4'h0;
    localparam logic [3:0] PWMST_OFS_MODE = 4'h4;
    localparam logic [3:0] PWMST_OFS_SHDN = 4'h8;
    localparam logic [3:0] PWMST_OFS_STEER = 4'hC;
    localparam logic [4:0] PWMST_OFS_RSTDB = 5'h10;
    localparam logic [4:0] PWMST_OFS_FLAG = 5'h14;
    localparam int PWMST_AW = 5;
    // mode register fields
    localparam int PWMST_MODE_CFG_LSB = 6;
    localparam int PWMST_MODE_SEL_HI = 2;
    localparam logic [1:0] PWMST_SEL_PWM = 2'h3;
    localparam logic [1:0] PWMST_CFG_SINGLE = 2'h0;
    localparam logic [1:0] PWMST_CFG_HALF = 2'h2;
    // shutdown register fields
    localparam int PWMST_SD_STATUS = 7;
    localparam int PWMST_SD_SRC_LSB = 4;
    localparam int PWMST_SD_A_LSB = 2;
    localparam int PWMST_SD_B_LSB = 0;
    localparam logic [1:0] PWMST_SS_LOW = 2'h0;
    localparam logic [1:0] PWMST_SS_HIGH = 2'h1;
    // steering register: writable mask (bits 7..5 unimplemented)
    localparam int PWMST_ST_SYNC = 4;
    localparam logic [7:0] PWMST_ST_MASK = 8'h1F;
    localparam logic [7:0] PWMST_RELOC_MASK = 8'h03;
    localparam int PWMST_RS_EN = 7;
    // resets
    localparam logic [7:0] PWMST_RST_BYTE = 8'h00;
    localparam logic [7:0] PWMST_RST_STEER = 8'h01;
    localparam logic [7:0] PWMST_RST_DIR = 8'hFF;
endpackage

// ### src/pwmst_deadband.sv
module pwmst_deadband
    import pwmst_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [6:0] delay_count,
    input wire logic level_in,
    output logic level_out
);
    logic [6:0] cnt_ff;
    logic [6:0] nxt_cnt;
    logic out_ff;
    logic nxt_out;
    wire rising_req = level_in & ~out_ff;

    // rising edge waits delay_count cycles, falling passes at once
    always_comb begin
        nxt_cnt = 7'h00;
        nxt_out = 1'b0;
        if (rising_req) begin
            nxt_cnt = (cnt_ff == delay_count) ? cnt_ff : cnt_ff + 7'h01;
            nxt_out = (cnt_ff == delay_count);
        end else begin
            nxt_out = level_in;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_ff <= 7'h00;
            out_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            out_ff <= nxt_out;
        end
    end

    assign level_out = out_ff;
endmodule

// ### verif/pwmst_top_properties.sv
module pwmst_top_properties
    import pwmst_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [1:0] pin_primary_oe,
    input wire logic [1:0] pin_alternate_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic dir_set_ff;
    // completed accesses
    wire logic req = avs_read || avs_write;
    wire logic wr_done = avs_write && !avs_waitrequest;
    wire logic rd_done = avs_read && !avs_waitrequest;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // remembers a direction write that opened a driver
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            dir_set_ff <= 1'b0;
        end else if (wr_done && avs_address == PWMST_OFS_FLAG && avs_writedata[7:6] != 2'h3) begin
            dir_set_ff <= 1'b1;
        end
    end
    // bus handshake: one wait state on every access
    a_wait_first: assert property (req && !$past(req) |-> avs_waitrequest)
        else $error("no wait state on a new access");
    a_wait_one: assert property (req && avs_waitrequest |=> !avs_waitrequest)
        else $error("access not answered after one wait state");
    a_idle_ready: assert property (!req |-> !avs_waitrequest)
        else $error("waitrequest high while idle");
    a_unmapped_zero: assert property (
        rd_done && avs_address > PWMST_OFS_FLAG |-> avs_readdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_upper_zero: assert property (rd_done |-> avs_readdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_steer_resv: assert property (
        rd_done && avs_address == PWMST_OFS_STEER |-> avs_readdata[7:5] == 3'h0)
        else $error("unimplemented steering bits not zero");
    a_oe_single: assert property ((pin_primary_oe & pin_alternate_oe) == 2'h0)
        else $error("pin driven at both locations");
    a_reset_hiz: assert property (
        !dir_set_ff |-> (pin_primary_oe | pin_alternate_oe) == 2'h0)
        else $error("driver on before direction write");
endmodule

// ### verif/pwmst_switch_model.sv
module pwmst_switch_model (
    input wire logic [1:0] pin_primary_out,
    input wire logic [1:0] pin_primary_oe,
    input wire logic [1:0] pin_alternate_out,
    input wire logic [1:0] pin_alternate_oe,
    output logic [1:0] pin_level
);
    timeunit 1ns;
    timeprecision 1ps;
    // pull-down keeps the switches off when no driver is on
    assign pin_level = (pin_primary_oe & pin_primary_out) |
        (pin_alternate_oe & pin_alternate_out);
endmodule

// ### verif/pwm_output_steering_test.sv
module pwm_output_steering_test;
    import pwmst_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 0, resetn = 0, avs_read = 0, avs_write = 0, period_match = 0, duty_active = 0;
    logic avs_waitrequest;
    logic [4:0] avs_address = 0;
    logic [31:0] avs_writedata = 0, avs_readdata;
    logic [2:0] shutdown_inputs = 0;
    logic [1:0] port_data = 0, pin_level, pin_primary_out, pin_primary_oe;
    logic [1:0] pin_alternate_out, pin_alternate_oe;
    logic [7:0] rdata;
    logic [7:0] rst_tab [7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'hC0, 8'h00};
    int err_total = 0, samples_checked = 0;
    pwmst_top u_dut (.sys_clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .period_match, .duty_active,
        .shutdown_inputs, .port_data, .pin_primary_out, .pin_primary_oe, .pin_alternate_out,
        .pin_alternate_oe);
    pwmst_switch_model u_sw (.pin_primary_out, .pin_primary_oe, .pin_alternate_out,
        .pin_alternate_oe, .pin_level);
    // system clock
    initial begin
        forever #5 sys_clk = !sys_clk;
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        samples_checked++;
        if (s !== e) begin
            err_total++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask
    // one access, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {24'h0, d};
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        rdata = avs_readdata[7:0];
        avs_read <= 0;
        avs_write <= 0;
    endtask
    task automatic rchk(input logic [4:0] a, input logic [7:0] e);
        bus(0, a, 8'h00);
        chk("reg", rdata, e);
    endtask
    // expected: primary oe, alternate oe, pin levels
    task automatic pins(input logic [5:0] e);
        repeat (3) @(posedge sys_clk);
        chk("pins", {2'h0, pin_primary_oe, pin_alternate_oe, pin_level}, {2'h0, e});
    endtask
    task automatic pulse();
        @(posedge sys_clk);
        period_match <= 1;
        @(posedge sys_clk);
        period_match <= 0;
    endtask
    task automatic mode(input logic [7:0] d);
        bus(1, PWMST_OFS_MODE, d);
        pulse();
    endtask
    // main sequence
    initial begin
        repeat (10) @(posedge sys_clk);
        resetn <= 1;
        for (int i = 0; i < 7; i++) begin
            rchk(5'(i * 4), rst_tab[i]);
        end
        bus(1, PWMST_OFS_STEER, 8'hFF);
        rchk(PWMST_OFS_STEER, PWMST_ST_MASK);
        bus(1, PWMST_OFS_RELOC, 8'hFF);
        rchk(PWMST_OFS_RELOC, PWMST_RELOC_MASK);
        bus(1, PWMST_OFS_RELOC, 8'h00);
        mode(8'h0C);
        rchk(PWMST_OFS_FLAG, 8'hC0);
        pulse();
        rchk(PWMST_OFS_FLAG, 8'hC1);
        bus(1, PWMST_OFS_FLAG, 8'h00);
        duty_active <= 1;
        bus(1, PWMST_OFS_STEER, 8'h01);
        pins(6'b110001);
        bus(1, PWMST_OFS_STEER, 8'h03);
        pins(6'b110011);
        duty_active <= 0;
        pins(6'b110000);
        duty_active <= 1;
        mode(8'h0E);
        pins(6'b110010);
        mode(8'h0D);
        pins(6'b110001);
        mode(8'h08);
        pins(6'b110000);
        mode(8'h0C);
        bus(1, PWMST_OFS_STEER, 8'h11);
        pins(6'b110011);
        pulse();
        pins(6'b110001);
        bus(1, PWMST_OFS_SHDN, 8'h12);
        shutdown_inputs <= 3'h1;
        pins(6'b110000);
        rchk(PWMST_OFS_SHDN, 8'h92);
        bus(1, PWMST_OFS_SHDN, 8'h12);
        rchk(PWMST_OFS_SHDN, 8'h92);
        shutdown_inputs <= 3'h0;
        pulse();
        rchk(PWMST_OFS_SHDN, 8'h92);
        bus(1, PWMST_OFS_SHDN, 8'h12);
        pulse();
        pins(6'b110001);
        bus(1, PWMST_OFS_RSTDB, 8'h80);
        shutdown_inputs <= 3'h1;
        rchk(PWMST_OFS_SHDN, 8'h92);
        shutdown_inputs <= 3'h0;
        pulse();
        rchk(PWMST_OFS_SHDN, 8'h12);
        pins(6'b110001);
        bus(1, PWMST_OFS_RELOC, 8'h01);
        pins(6'b100101);
        // half-bridge: complement rises three cycles late
        bus(1, PWMST_OFS_RELOC, 8'h00);
        bus(1, PWMST_OFS_RSTDB, 8'h03);
        mode(8'h8C);
        duty_active <= 0;
        pins(6'b110000);
        pins(6'b110010);
        test_done();
    end
    // watchdog
    initial begin
        #50us;
        err_total++;
        test_done();
    end
endmodule
bind pwmst_top pwmst_top_properties u_props (.sys_clk, .resetn, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .pin_primary_oe,
    .pin_alternate_oe);
